//--- design/flash_pin_pkg.sv
/*
 * constants and carrier types for the serial flash pin interface.
 * assumes a 100 mhz system clock; the serial clock comes from the host.
 */
package flash_pin_pkg;
	// system clock period and pin timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_PULSE_TIME_NS = 200;
	localparam int RESET_PULSE_CYCLES =
		(RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int KEEP_HIGH_TIME_NS = 50;
	localparam int KEEP_HIGH_CYCLES =
		(KEEP_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// instruction length and pin positions
	localparam int INSTR_BITS = 8;
	localparam int WP_PIN = 2;
	localparam int RESET_PIN = 3;
	// transfer width of address and data phases
	typedef enum logic [1:0] {
		WIDTH_SINGLE = 2'h0,
		WIDTH_DUAL = 2'h1,
		WIDTH_QUAD = 2'h2
	} width_t;
	// configuration bits held by the register logic outside
	typedef struct packed {
		logic quad_enable;
		logic reset_enable;
		logic status_write_disable_nv;
		logic ddr;
		width_t width;
		logic cont_read;
	} mode_t;
	// drive of the four data pins
	typedef struct packed {
		logic [3:0] o;
		logic [3:0] oe;
	} pin_drive_t;
endpackage : flash_pin_pkg

//--- design/flash_pin_if.sv
/*
 * pin side of a multi-i/o serial flash: shifts bytes in and out on the
 * serial clock, gates write protect, detects the shared-pin reset.
 * assumes command decode, registers and array live outside on clk;
 * the host keeps tx_data stable until tx_next and sets mode before
 * a frame starts.
 */
// Notes on behaviour
// - input bits latched on rising clock only
// - outputs change after falling, ddr every edge
// - deselected: inputs ignored, outputs high impedance except the line 3 keeper
// - deselected means standby unless busy; busy shown
// - select low moves device to active state
// - no command before first select falling edge
// - single commands shift data on output line
// - line zero bidirectional in dual and quad
// - line one bidirectional in dual and quad
// - protect low with disable bit blocks writes
// - quad enable turns protect pin into data
// - quad mode uses fourth pin as data
// - fourth pin resets only when enabled, deselected
// - reset needs select high, pin low, full time
// - device drives fourth pin high after reads when reset enabled
// - reset bit clear: never a reset
// - commands open with instruction byte unless continuous
// - disable bit and no quad: pin protects
`timescale 1ns/1ps
module flash_pin_if
	import flash_pin_pkg::*;
#(
	parameter int RST_CNT_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe,
	input wire mode_t mode,
	input wire logic busy,
	input wire logic status_write_req,
	input wire logic sr1cr1_write_req,
	input wire logic [7:0] tx_data,
	input wire logic tx_enable,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_first,
	output logic tx_next,
	output logic selected,
	output logic standby,
	output logic wip,
	output logic cmd_armed,
	output logic write_ignored,
	output logic hw_reset
);
	// reset detector states
	typedef enum logic [1:0] {
		RST_IDLE = 2'h0,
		RST_COUNT = 2'h1,
		RST_FIRED = 2'h2
	} rst_state_t;

	localparam logic [RST_CNT_W-1:0] CNT_LAST =
		RST_CNT_W'(RESET_PULSE_CYCLES - 1);
	localparam logic [7:0] KEEP_LOAD = 8'(KEEP_HIGH_CYCLES);

	// ---------------- link side, serial clock domain ----------------

	// mode bits carried into the serial clock domain
	logic [5:0] lk_s1_r, lk_s2_r, lk_nxt;
	width_t lk_width; // effective width, quad only when enabled
	logic lk_ddr, lk_tx_on, lk_cont;

	// two flops on sck; the host sets mode well before the frame
	always_comb begin
		lk_nxt = {mode.quad_enable, mode.width, mode.ddr, tx_enable,
			mode.cont_read};
	end
	// sys_rst clears these while sck is parked, so release is safe
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			lk_s1_r <= 6'h00;
			lk_s2_r <= 6'h00;
		end else begin
			lk_s1_r <= lk_nxt;
			lk_s2_r <= lk_s1_r;
		end
	end
	always_comb begin
		lk_width = width_t'(lk_s2_r[4:3]);
		if (lk_width == WIDTH_QUAD && !lk_s2_r[5])
			lk_width = WIDTH_SINGLE; // quad phases need quad enable
		lk_ddr = lk_s2_r[2];
		lk_tx_on = lk_s2_r[1];
		lk_cont = lk_s2_r[0];
	end

	// receive shifter, cleared by the frame's own select
	logic [3:0] in_cnt_r, in_cnt_nxt;
	logic [7:0] in_sh_r, in_sh_nxt;
	logic instr_r, instr_nxt; // next byte is the instruction
	logic byte_done;
	always_comb begin
		in_sh_nxt = in_sh_r;
		in_cnt_nxt = in_cnt_r;
		instr_nxt = instr_r;
		byte_done = 1'b0;
		if (instr_r || lk_width == WIDTH_SINGLE) begin
			in_sh_nxt = {in_sh_r[6:0], io_i[0]};
			in_cnt_nxt = in_cnt_r + 4'h1;
		end else if (lk_width == WIDTH_DUAL) begin
			in_sh_nxt = {in_sh_r[5:0], io_i[1:0]};
			in_cnt_nxt = in_cnt_r + 4'h2;
		end else begin
			in_sh_nxt = {in_sh_r[3:0], io_i};
			in_cnt_nxt = in_cnt_r + 4'h4;
		end
		if (in_cnt_nxt == 4'(INSTR_BITS)) begin
			byte_done = 1'b1;
			in_cnt_nxt = 4'h0;
			instr_nxt = 1'b0;
		end
	end
	// deselect holds the shifter in reset: inputs are ignored
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			in_sh_r <= 8'h00;
			in_cnt_r <= 4'h0;
			instr_r <= 1'b1;
		end else begin
			in_sh_r <= in_sh_nxt;
			in_cnt_r <= in_cnt_nxt;
			instr_r <= instr_nxt & ~lk_cont;
		end
	end
	// continuous read skips the instruction; lk_cont masks it above
	// only after the first edge, so the first bit is taken single-bit

	// received byte hand-off; toggle and hold survive the frame end
	logic [8:0] rx_hold_r, rx_hold_nxt;
	logic rx_tog_r, rx_tog_nxt;
	always_comb begin
		rx_hold_nxt = rx_hold_r;
		rx_tog_nxt = rx_tog_r;
		if (!cs_n && byte_done) begin
			rx_hold_nxt = {instr_r & ~lk_cont, in_sh_nxt};
			rx_tog_nxt = ~rx_tog_r;
		end
	end
	// toggle starts known so the first hand-off is not unknown
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			rx_hold_r <= 9'h000;
			rx_tog_r <= 1'b0;
		end else begin
			rx_hold_r <= rx_hold_nxt;
			rx_tog_r <= rx_tog_nxt;
		end
	end

	// transmit shifter on the falling edge
	logic [7:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_cnt_r, tx_cnt_nxt, tx_step;
	logic tx_act_r, tx_act_nxt;
	logic tx_tog_r, tx_tog_nxt;
	always_comb begin
		case (lk_width)
			WIDTH_DUAL: tx_step = 4'h2;
			WIDTH_QUAD: tx_step = 4'h4;
			default: tx_step = 4'h1;
		endcase
		if (lk_ddr)
			tx_step = tx_step << 1;
		tx_sh_nxt = tx_sh_r << tx_step;
		tx_cnt_nxt = tx_cnt_r + tx_step;
		tx_act_nxt = lk_tx_on;
		tx_tog_nxt = tx_tog_r;
		if (!lk_tx_on) begin
			tx_cnt_nxt = 4'h0;
		end else if (tx_cnt_r == 4'h0 || tx_cnt_r == 4'(INSTR_BITS)) begin
			tx_sh_nxt = tx_data; // next byte, then tell the host
			tx_cnt_nxt = tx_step;
			tx_tog_nxt = ~tx_tog_r;
		end
	end
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 4'h0;
			tx_act_r <= 1'b0;
		end else begin
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_act_r <= tx_act_nxt;
		end
	end
	always_ff @(negedge sck or posedge sys_rst) begin
		if (sys_rst)
			tx_tog_r <= 1'b0;
		else
			tx_tog_r <= tx_act_nxt ? tx_tog_nxt : tx_tog_r;
	end

	// pin pattern for the top bits of a byte at the given width
	function automatic pin_drive_t fmt(input logic [7:0] b,
		input width_t w);
		pin_drive_t d;
		d = '0;
		case (w)
			WIDTH_DUAL: begin
				d.o = {2'h0, b[7:6]};
				d.oe = 4'h3;
			end
			WIDTH_QUAD: begin
				d.o = b[7:4];
				d.oe = 4'hf;
			end
			default: begin
				d.o = {2'h0, b[7], 1'b0};
				d.oe = 4'h2;
			end
		endcase
		return d;
	endfunction : fmt

	// ddr sends the second group while the clock is high
	pin_drive_t link_drv;
	logic [7:0] tx_second;
	always_comb begin
		tx_second = tx_sh_r << tx_step[3:1];
		if (lk_ddr && sck)
			link_drv = fmt(tx_second, lk_width);
		else
			link_drv = fmt(tx_sh_r, lk_width);
		if (!tx_act_r)
			link_drv.oe = 4'h0;
	end

	// ---------------- system clock domain ----------------

	// pin and toggle synchronisers; stage one feeds stage two only
	logic [4:0] sy1_r, sy2_r, sy_nxt;
	always_comb begin
		sy_nxt = {cs_n, io_i[RESET_PIN], io_i[WP_PIN], rx_tog_r, tx_tog_r};
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sy1_r <= 5'h1c;
			sy2_r <= 5'h1c;
		end else if (ce) begin
			sy1_r <= sy_nxt;
			sy2_r <= sy1_r;
		end
	end
	logic cs_s, io3_s, wp_s, rxt_s, txt_s;
	always_comb begin
		{cs_s, io3_s, wp_s, rxt_s, txt_s} = sy2_r;
	end

	// status, hand-off and protection outputs
	logic cs_prev_r, rxt_prev_r, txt_prev_r, read_seen_r;
	logic cs_prev_nxt, rxt_prev_nxt, txt_prev_nxt, read_seen_nxt;
	logic [7:0] rx_byte_nxt, keep_cnt_r, keep_cnt_nxt;
	logic rx_valid_nxt, rx_first_nxt, tx_next_nxt, armed_nxt;
	logic sel_nxt, stby_nxt, wip_nxt, wign_nxt, hw_nxt;
	logic rst_cond;
	rst_state_t rst_state_r, rst_state_nxt;
	logic [RST_CNT_W-1:0] rst_cnt_r, rst_cnt_nxt;

	always_comb begin
		cs_prev_nxt = cs_s;
		rxt_prev_nxt = rxt_s;
		txt_prev_nxt = txt_s;
		// a command only counts once a select fall was seen
		armed_nxt = cmd_armed | (cs_prev_r & ~cs_s);
		if (hw_reset)
			armed_nxt = 1'b0;
		rx_valid_nxt = (rxt_s ^ rxt_prev_r) & armed_nxt;
		rx_byte_nxt = rx_valid_nxt ? rx_hold_r[7:0] : rx_byte;
		rx_first_nxt = rx_valid_nxt ? rx_hold_r[8] : rx_first;
		tx_next_nxt = txt_s ^ txt_prev_r;
		sel_nxt = ~cs_s;
		stby_nxt = cs_s & ~busy;
		wip_nxt = busy;
		// protect pin acts only outside quad mode
		wign_nxt = mode.status_write_disable_nv & ~mode.quad_enable &
			~wp_s & (status_write_req | sr1cr1_write_req);
		// hold data line 3 high after a read, only while deselected
		read_seen_nxt = read_seen_r | (tx_enable & ~cs_s);
		keep_cnt_nxt = keep_cnt_r;
		if (!cs_s)
			keep_cnt_nxt = 8'h00;
		else if (keep_cnt_r != 8'h00)
			keep_cnt_nxt = keep_cnt_r - 8'h01;
		if (cs_s && !cs_prev_r) begin
			if (read_seen_r && mode.reset_enable)
				keep_cnt_nxt = KEEP_LOAD;
			read_seen_nxt = 1'b0;
		end
	end

	// reset pin is a reset only when enabled and deselected
	always_comb begin
		rst_cond = mode.reset_enable & cs_s & ~io3_s;
		rst_state_nxt = rst_state_r;
		rst_cnt_nxt = rst_cnt_r;
		hw_nxt = 1'b0;
		case (rst_state_r)
			RST_IDLE: begin
				rst_cnt_nxt = '0;
				if (rst_cond)
					rst_state_nxt = RST_COUNT;
			end
			RST_COUNT: begin
				if (!rst_cond) begin
					rst_state_nxt = RST_IDLE;
				end else if (rst_cnt_r == CNT_LAST) begin
					rst_state_nxt = RST_FIRED;
					hw_nxt = 1'b1;
				end else begin
					rst_cnt_nxt = rst_cnt_r + 1'b1;
				end
			end
			RST_FIRED: begin
				if (!rst_cond)
					rst_state_nxt = RST_IDLE;
			end
			default: rst_state_nxt = RST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cs_prev_r <= 1'b1;
			rxt_prev_r <= 1'b0;
			txt_prev_r <= 1'b0;
			read_seen_r <= 1'b0;
			keep_cnt_r <= 8'h00;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
			tx_next <= 1'b0;
			cmd_armed <= 1'b0;
			selected <= 1'b0;
			standby <= 1'b0;
			wip <= 1'b0;
			write_ignored <= 1'b0;
			hw_reset <= 1'b0;
			rst_state_r <= RST_IDLE;
			rst_cnt_r <= '0;
		end else if (ce) begin
			cs_prev_r <= cs_prev_nxt;
			rxt_prev_r <= rxt_prev_nxt;
			txt_prev_r <= txt_prev_nxt;
			read_seen_r <= read_seen_nxt;
			keep_cnt_r <= keep_cnt_nxt;
			rx_byte <= rx_byte_nxt;
			rx_valid <= rx_valid_nxt;
			rx_first <= rx_first_nxt;
			tx_next <= tx_next_nxt;
			cmd_armed <= armed_nxt;
			selected <= sel_nxt;
			standby <= stby_nxt;
			wip <= wip_nxt;
			write_ignored <= wign_nxt;
			hw_reset <= hw_nxt;
			rst_state_r <= rst_state_nxt;
			rst_cnt_r <= rst_cnt_nxt;
		end
	end

	// pins: link drive only while selected, keeper on line 3 after
	logic keep_on;
	always_comb begin
		keep_on = (keep_cnt_r != 8'h00);
		io_o = link_drv.o;
		io_oe = cs_n ? 4'h0 : link_drv.oe;
		if (keep_on) begin
			io_o[RESET_PIN] = 1'b1;
			io_oe[RESET_PIN] = 1'b1;
		end
	end

	// ---------------- checks ----------------

	sequence rst_start_s;
		!rst_cond ##1 rst_cond;
	endsequence

	armed_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		rx_valid |-> cmd_armed)
		else $error("byte delivered before select fall");
	reset_full_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(hw_reset) |-> $past(rst_cnt_r) == CNT_LAST && $past(rst_cond))
		else $error("reset fired before full pulse");
	reset_early_a: assert property (@(posedge clk)
		disable iff (sys_rst || !ce)
		rst_start_s |=> !hw_reset [*8])
		else $error("reset fired too soon");
	short_pulse_a: assert property (@(posedge clk)
		disable iff (sys_rst || !ce)
		rst_state_r == RST_COUNT && !rst_cond |=>
		rst_state_r == RST_IDLE && !hw_reset)
		else $error("short reset pulse not ignored");
	reset_off_a: assert property (@(posedge clk)
		disable iff (sys_rst || !ce)
		!mode.reset_enable |=> !hw_reset)
		else $error("reset taken while disabled");
	deselect_hiz_a: assert property (@(posedge clk) disable iff (sys_rst)
		cs_n && !keep_on |-> io_oe == 4'h0)
		else $error("pins driven while deselected");
	wp_block_a: assert property (@(posedge clk)
		disable iff (sys_rst || !ce)
		mode.status_write_disable_nv && !mode.quad_enable && !wp_s &&
		status_write_req |=> write_ignored)
		else $error("protected write not ignored");
	quad_no_wp_a: assert property (@(posedge clk)
		disable iff (sys_rst || !ce)
		mode.quad_enable |=> !write_ignored)
		else $error("protect active in quad mode");
	standby_wip_a: assert property (@(posedge clk)
		disable iff (sys_rst || !ce)
		cs_s && busy |=> !standby && wip)
		else $error("standby while busy");
	keeper_a: assert property (@(posedge clk) disable iff (sys_rst)
		keep_on |-> io_o[RESET_PIN] && io_oe[RESET_PIN] && cs_s)
		else $error("line 3 not held high");
endmodule : flash_pin_if

//--- testbench/spi_host.sv
/*
 * behavioural spi host for the flash pin block: frames, byte shifts
 * at 1, 2 or 4 bits a clock, reads, and static drive of single pins.
 * assumes the bench resolves the shared io wires and their pull-ups.
 */
`timescale 1ns/1ps
module spi_host (
	output logic cs_n,
	output logic sck,
	output logic [3:0] h_o,
	output logic [3:0] h_oe,
	input wire logic [3:0] io
);
	// idle: deselected, clock parked low, pins released
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		h_o = 4'h0;
		h_oe = 4'h0;
	end
	// selecting gives the falling edge that arms the device
	task automatic sel();
		cs_n = 1'b0;
		#7;
	endtask : sel
	// end of frame; after writes io3 goes high with the select rise
	task automatic desel(input logic drv);
		h_o[3] = 1'b1;
		h_oe[3] = drv;
		cs_n = 1'b1;
	endtask : desel
	// release every pin again
	task automatic rel();
		h_oe = 4'h0;
	endtask : rel
	// two dummy clocks: lets the device see its read enable on sck
	task automatic gap();
		repeat (2) begin
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
	endtask : gap
	// static level on one pin, used for protect and reset
	task automatic pin(input int i, input logic v);
		h_o[i] = v;
		h_oe[i] = 1'b1;
	endtask : pin
	// one byte out, msb group first, lsb of a group on io0
	task automatic put(input logic [7:0] b, input int w);
		logic [7:0] s;
		s = b;
		h_oe = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
		repeat (8 / w) begin
			h_o = (w == 1) ? {3'h0, s[7]} : (w == 2) ? {2'h0, s[7:6]} : s[7:4];
			#6 sck = 1'b1;
			#6 sck = 1'b0;
			s = s << w;
		end
	endtask : put
	// one byte in, sampled on rising edges while the pins are free
	task automatic get(input int w, output logic [7:0] b);
		h_oe = 4'h0;
		b = 8'h0;
		repeat (8 / w) begin
			#6 sck = 1'b1;
			b = (w == 1) ? {b[6:0], io[1]} : (w == 2) ? {b[5:0], io[1:0]}
				: {b[3:0], io};
			#6 sck = 1'b0;
		end
	endtask : get
endmodule : spi_host

//--- testbench/testbench.sv
/*
 * self-checking bench for the flash pin block: frames of each width,
 * reads with the io3 keeper, protect gating, shared-pin reset.
 * assumes the pin block of the design package; no register bus.
 */
`timescale 1ns/1ps
module testbench;
	import flash_pin_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b0, ce = 1'b1, busy = 1'b0, flt = 1'b0;
	logic sw_req = 1'b0, ar_req = 1'b0, tx_enable = 1'b0;
	logic [7:0] tx_data = 8'h0, rx_b, rx_byte;
	mode_t mode = '0;
	logic [3:0] io_i, io_o, io_oe, h_o, h_oe;
	logic cs_n, sck, rx_valid, rx_first, rx_f, selected, standby, wip;
	logic cmd_armed, write_ignored, hw_reset;
	int fail_count = 0, n_checks = 0, cyc = 0, rst_seen = 0;
	always #5 clk = ~clk;
	// wire level: device, then host, then pull-up or a toggling float
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io_i[i] = io_oe[i] ? io_o[i] : h_oe[i] ? h_o[i] : (i > 1) | flt;
		end
	end
	flash_pin_if u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sck(sck),
		.cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .mode(mode),
		.busy(busy), .status_write_req(sw_req), .sr1cr1_write_req(ar_req),
		.tx_data(tx_data), .tx_enable(tx_enable), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_first(rx_first), .tx_next(),
		.selected(selected), .standby(standby), .wip(wip),
		.cmd_armed(cmd_armed), .write_ignored(write_ignored),
		.hw_reset(hw_reset));
	// one memory alone on the shared line 3
	spi_host u_host (.cs_n(cs_n), .sck(sck), .h_o(h_o), .h_oe(h_oe),
		.io(io_i));
	// capture one-cycle pulses and cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		flt <= ~flt;
		if (rx_valid === 1'b1) begin
			rx_b <= rx_byte;
			rx_f <= rx_first;
		end
		if (hw_reset === 1'b1)
			rst_seen <= rst_seen + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// mode is only changed between frames
	task automatic setm(input logic q, input logic r, input logic d,
		input width_t w);
		@(posedge clk);
		mode <= '{q, r, d, 1'b0, w, 1'b0};
		tick(3);
	endtask : setm
	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	initial begin
		width_t wl[3] = '{WIDTH_SINGLE, WIDTH_DUAL, WIDTH_QUAD};
		int wn[3] = '{1, 2, 4};
		logic [7:0] b;
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		tick(2);
		check("selected", 8'(selected), 8'h0);
		check("standby", 8'(standby), 8'h1);
		check("armed", 8'(cmd_armed), 8'h0);
		check("oe idle", 8'(io_oe), 8'h0);
		// embedded operation keeps the part out of standby
		@(posedge clk) busy <= 1'b1;
		tick(4);
		check("standby busy", 8'(standby), 8'h0);
		check("wip", 8'(wip), 8'h1);
		@(posedge clk) busy <= 1'b0;
		// write frames at each width
		for (int k = 0; k < 3; k++) begin
			setm(1'b1, 1'b0, 1'b0, wl[k]);
			u_host.sel();
			tick(3);
			check("selected", 8'(selected), 8'h1);
			check("active", 8'(standby), 8'h0);
			check("armed", 8'(cmd_armed), 8'h1);
			u_host.put(8'h9e, 1);
			tick(6);
			check("instr", rx_b, 8'h9e);
			check("first", 8'(rx_f), 8'h1);
			u_host.put(8'h5c + 8'(k), wn[k]);
			tick(6);
			check("data", rx_b, 8'h5c + 8'(k));
			check("not first", 8'(rx_f), 8'h0);
			u_host.desel(1'b1);
			tick(3);
			check("oe deselected", 8'(io_oe), 8'h0);
			u_host.rel();
		end
		// reads, single and quad, then the io3 keeper
		for (int k = 0; k < 3; k += 2) begin
			setm(1'b1, 1'b1, 1'b0, wl[k]);
			@(posedge clk) tx_data <= 8'hc3 ^ 8'(k);
			tick(4);
			u_host.sel();
			u_host.put(8'h6b, 1);
			u_host.rel();
			@(posedge clk) tx_enable <= 1'b1;
			tick(2);
			u_host.gap();
			u_host.get(wn[k], b);
			check("read", b, 8'hc3 ^ 8'(k));
			u_host.desel(1'b0);
			tick(4);
			check("keeper oe", 8'(io_oe), 8'h8);
			check("keeper level", 8'(io_o[3]), 8'h1);
			@(posedge clk) tx_enable <= 1'b0;
			tick(8);
		end
		check("no reset", 8'(rst_seen), 8'h0);
		// protect gating on io2
		setm(1'b0, 1'b0, 1'b1, WIDTH_SINGLE);
		u_host.pin(2, 1'b0);
		@(posedge clk) sw_req <= 1'b1;
		tick(5);
		check("protect status", 8'(write_ignored), 8'h1);
		@(posedge clk) sw_req <= 1'b0;
		ar_req <= 1'b1;
		tick(5);
		check("protect any", 8'(write_ignored), 8'h1);
		setm(1'b1, 1'b0, 1'b1, WIDTH_SINGLE);
		tick(3);
		check("quad no protect", 8'(write_ignored), 8'h0);
		setm(1'b0, 1'b0, 1'b1, WIDTH_SINGLE);
		u_host.pin(2, 1'b1);
		tick(5);
		check("pin high", 8'(write_ignored), 8'h0);
		@(posedge clk) ar_req <= 1'b0;
		u_host.rel();
		// shared-pin reset: short pulse, full pulse, disabled, selected
		setm(1'b0, 1'b1, 1'b0, WIDTH_SINGLE);
		u_host.pin(3, 1'b0);
		#((RESET_PULSE_CYCLES / 2) * 10);
		u_host.pin(3, 1'b1);
		tick(5);
		check("short pulse", 8'(rst_seen), 8'h0);
		u_host.pin(3, 1'b0);
		#((RESET_PULSE_CYCLES + 8) * 10);
		u_host.pin(3, 1'b1);
		tick(5);
		check("reset", 8'(rst_seen), 8'h1);
		check("disarmed", 8'(cmd_armed), 8'h0);
		setm(1'b0, 1'b0, 1'b0, WIDTH_SINGLE);
		u_host.pin(3, 1'b0);
		#((RESET_PULSE_CYCLES + 8) * 10);
		u_host.pin(3, 1'b1);
		tick(5);
		check("reset disabled", 8'(rst_seen), 8'h1);
		setm(1'b1, 1'b1, 1'b0, WIDTH_QUAD);
		u_host.sel();
		u_host.pin(3, 1'b0);
		#((RESET_PULSE_CYCLES + 8) * 10);
		u_host.desel(1'b1);
		tick(5);
		check("reset selected", 8'(rst_seen), 8'h1);
		u_host.rel();
		finish_test();
	end
endmodule : testbench
